/* File: rtl/ctc_pkg.sv */
`default_nettype none
// ----------------------------------------------------------------
// shared constants of the top-off and termination configuration bank
// ----------------------------------------------------------------
package ctc_pkg;
  // register index on the configuration port
  localparam logic [7:0] TOPOFF_CFG_OFS = 8'h19;
  localparam logic [7:0] SYS_TERM_CFG_OFS = 8'h1a;
  // reset values: spare 0, duration 011, threshold 0010
  localparam logic [7:0] TOPOFF_CFG_RST = 8'h32;
  // reset values: follow enabled, min sys 01, term code 0x04
  localparam logic [7:0] SYS_TERM_CFG_RST = 8'h24;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;
  // field positions inside the top-off register
  localparam int SPARE_BIT = 7;
  localparam int DUR_LSB = 4;
  localparam int DUR_W = 3;
  localparam int ITH_LSB = 0;
  localparam int ITH_W = 4;
  // field positions inside the system / termination register
  localparam int FOLLOW_DIS_BIT = 7;
  localparam int MIN_SYSTEM_VOLTAGE_LSB = 5;
  localparam int MIN_SYSTEM_VOLTAGE_W = 2;
  localparam int TERM_LSB = 0;
  localparam int TERM_W = 5;
  // fast-charge current decode, in mA
  localparam logic [6:0] CC_FLOOR_CODE = 7'h02;
  localparam logic [6:0] CC_MAX_CODE = 7'h6e;
  localparam logic [12:0] CC_FLOOR_MA = 13'h0064;
  localparam logic [12:0] CC_STEP_MA = 13'h0032;
  // top-off threshold decode, in mA
  localparam logic [3:0] ITH_DISABLE = 4'h0;
  localparam logic [9:0] ITH_BASE_MA = 10'h0096;
  localparam logic [9:0] ITH_STEP_MA = 10'h0032;
  // top-off duration: short run in seconds, longer runs in steps of minutes
  localparam int TOPOFF_SHORT_S = 30;
  localparam int TOPOFF_STEP_MIN = 10;
  localparam int SEC_PER_MIN = 60;
  localparam logic [DUR_W-1:0] DUR_SHORT_CODE = 3'h0;
  // voltages in units of 100 uV
  localparam logic [16:0] TERM_BASE_A = 17'h0_a21c;
  localparam logic [16:0] TERM_STEP_A = 17'h0_007d;
  localparam logic [16:0] TERM_BASE_B = 17'h0_88b8;
  localparam logic [16:0] TERM_STEP_B = 17'h0_00fa;
  // minimum system levels, variant a then variant b
  localparam logic [16:0] MIN_SYSTEM_VOLTAGE_A0 = 17'h0_84d0;
  localparam logic [16:0] MIN_SYSTEM_VOLTAGE_A1 = 17'h0_88b8;
  localparam logic [16:0] MIN_SYSTEM_VOLTAGE_A2 = 17'h0_8ca0;
  localparam logic [16:0] MIN_SYSTEM_VOLTAGE_A3 = 17'h0_9088;
  localparam logic [16:0] MIN_SYSTEM_VOLTAGE_B0 = 17'h0_7530;
  localparam logic [16:0] MIN_SYSTEM_VOLTAGE_B1 = 17'h0_7918;
  localparam logic [16:0] MIN_SYSTEM_VOLTAGE_B2 = 17'h0_88b8;
  localparam logic [16:0] MIN_SYSTEM_VOLTAGE_B3 = 17'h0_8ca0;
  // battery + 4 percent is battery + battery / 25
  localparam logic [16:0] FOLLOW_DIV = 17'h0_0019;
  // charger state details codes
  localparam logic [3:0] DTLS_FAST = 4'h3;
  localparam logic [3:0] DTLS_TOPOFF = 4'h4;
  localparam logic [3:0] DTLS_DONE = 4'h5;
  localparam logic [3:0] DTLS_OFF = 4'h8;
  // clock
  localparam int CLK_HZ = 125_000_000;
  typedef enum logic [1:0] {ST_OFF, ST_FAST, ST_TOPOFF, ST_DONE} ctc_state_t;
endpackage
`default_nettype wire

/* File: rtl/ctc_timer_if.sv */
`default_nettype none
// ----------------------------------------------------------------
// link between the charge state logic and the top-off timer
// ----------------------------------------------------------------
interface ctc_timer_if;
  logic start; // one-cycle pulse, loads the duration
  logic stop; // one-cycle pulse, abandons the run
  logic [2:0] duration; // duration code taken with start
  logic expired; // one-cycle pulse at the end of the run
  modport ctl (output start, output stop, output duration, input expired);
  modport tmr (input start, input stop, input duration, output expired);
endinterface
`default_nettype wire

/* File: rtl/ctc_topoff_timer.sv */
`default_nettype none
// ----------------------------------------------------------------
// top-off timer: one-second prescaler and seconds down-counter
// ----------------------------------------------------------------
module ctc_topoff_timer #(
  parameter int unsigned CYCLES_PER_SEC = ctc_pkg::CLK_HZ
) (
  input wire logic clk,
  input wire logic resetn,
  ctc_timer_if.tmr tif
);
  logic [31:0] pre_q; // cycles within the current second
  logic [12:0] sec_q; // seconds still to run
  logic run_q; // a run is in progress
  logic exp_q; // end-of-run pulse
  logic sec_tick; // last cycle of a second

  assign sec_tick = (pre_q == 32'(CYCLES_PER_SEC - 1));
  assign tif.expired = exp_q;

  // seconds requested by a duration code
  function automatic logic [12:0] dur_seconds(input logic [2:0] code);
    if (code == ctc_pkg::DUR_SHORT_CODE) begin
      return 13'(ctc_pkg::TOPOFF_SHORT_S);
    end
    return 13'(32'(code) * ctc_pkg::TOPOFF_STEP_MIN * ctc_pkg::SEC_PER_MIN);
  endfunction

  // prescaler restarts with every run so each second is whole
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= 32'h0000_0000;
    end else if (tif.start || !run_q || sec_tick) begin
      pre_q <= 32'h0000_0000;
    end else begin
      pre_q <= pre_q + 32'h0000_0001;
    end
  end

  // down-counter; start wins over a stop in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sec_q <= 13'h0000;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      exp_q <= 1'b0;
      if (tif.start) begin
        sec_q <= dur_seconds(tif.duration);
        run_q <= 1'b1;
      end else if (tif.stop) begin
        run_q <= 1'b0;
      end else if (run_q && sec_tick) begin
        if (sec_q == 13'h0001) begin
          run_q <= 1'b0;
          exp_q <= 1'b1;
        end
        sec_q <= sec_q - 13'h0001;
      end
    end
  end
endmodule // ctc_topoff_timer
`default_nettype wire

/* File: rtl/ctc_top.sv */
`default_nettype none
// Function
// - current code steps 50mA, saturates above 0x6E
// - duration code: 30s or 10-70 minutes
// - constant-voltage current at threshold enters top-off
// - top-off entry pulses event, reports top-off
// - top-off entry starts timer with duration
// - threshold code zero disables, else 150-850mA
// - follow enabled: max(battery+4%, minimum system)
// - following stays in force after charge done
// - follow disabled: regulate to termination voltage
// - minimum system code picks level per variant
// - termination code sets voltage per variant
module ctc_top #(
  parameter bit VARIANT_B = 1'b0, // selects the second voltage tables
  parameter int unsigned CYCLES_PER_SEC = ctc_pkg::CLK_HZ
) (
  input wire logic clk,
  input wire logic resetn,
  // register port behind the serial configuration engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // charger context
  input wire logic charge_enable, // charger enabled, same clock
  input wire logic cv_mode_pin, // analog loop in constant voltage
  input wire logic buck_mode_pin, // converter running as buck
  input wire logic [12:0] charge_current_ma, // measured current, same clock
  input wire logic [15:0] battery_voltage, // 100 uV units, same clock
  input wire logic [6:0] fast_charge_current_code,
  // results
  output logic [12:0] charge_current_limit_ma,
  output logic [9:0] topoff_threshold_ma,
  output logic [16:0] battery_term_voltage,
  output logic [16:0] sys_regulation_target,
  output logic sys_target_valid,
  output logic [3:0] charger_state_details,
  output logic charger_event_irq
);
  // ----------------------------------------------------------------
  // registers and synchronisers
  // ----------------------------------------------------------------
  logic [7:0] topoff_config_q; // top-off register
  logic [7:0] sys_term_cfg_q; // system / termination register
  logic cv_s1_q, cv_s2_q; // constant-voltage synchroniser
  logic buck_s1_q, buck_s2_q; // buck-mode synchroniser
  ctc_pkg::ctc_state_t state_q, state_d; // charge progress
  logic enter_topoff; // one cycle, transition into top-off
  logic [3:0] ith_code; // threshold field
  logic [9:0] ith_ma; // decoded threshold
  logic [16:0] term_v; // decoded termination voltage
  logic [16:0] min_system_voltage_v; // decoded minimum system voltage
  logic [16:0] follow_v; // battery plus four percent
  ctc_timer_if tif ();

  assign ith_code = topoff_config_q[ctc_pkg::ITH_LSB +: ctc_pkg::ITH_W];

  // threshold decode in mA
  function automatic logic [9:0] ith_decode(input logic [3:0] code);
    if (code == ctc_pkg::ITH_DISABLE) begin
      return 10'h000;
    end
    return ctc_pkg::ITH_BASE_MA + 10'(32'(code - 4'h1) * 32'(ctc_pkg::ITH_STEP_MA));
  endfunction

  // termination voltage decode in 100 uV
  function automatic logic [16:0] term_decode(input logic [4:0] code, input logic var_b);
    logic [16:0] base;
    logic [16:0] step;
    base = var_b ? ctc_pkg::TERM_BASE_B : ctc_pkg::TERM_BASE_A;
    step = var_b ? ctc_pkg::TERM_STEP_B : ctc_pkg::TERM_STEP_A;
    return base + 17'(32'(code) * 32'(step));
  endfunction

  // ----------------------------------------------------------------
  // register writes; all fields are plain read-write
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      topoff_config_q <= ctc_pkg::TOPOFF_CFG_RST;
      sys_term_cfg_q <= ctc_pkg::SYS_TERM_CFG_RST;
    end else if (reg_wr) begin
      if (reg_addr == ctc_pkg::TOPOFF_CFG_OFS) begin
        topoff_config_q <= reg_wdata;
      end
      if (reg_addr == ctc_pkg::SYS_TERM_CFG_OFS) begin
        sys_term_cfg_q <= reg_wdata;
      end
    end
  end

  // read data registered one cycle after the read strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= ctc_pkg::UNMAPPED_RDATA;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ctc_pkg::TOPOFF_CFG_OFS: reg_rdata <= topoff_config_q;
        ctc_pkg::SYS_TERM_CFG_OFS: reg_rdata <= sys_term_cfg_q;
        default: reg_rdata <= ctc_pkg::UNMAPPED_RDATA;
      endcase
    end
  end

  // analog status pins cross into the clock domain
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cv_s1_q <= 1'b0;
      cv_s2_q <= 1'b0;
      buck_s1_q <= 1'b0;
      buck_s2_q <= 1'b0;
    end else begin
      cv_s1_q <= cv_mode_pin;
      cv_s2_q <= cv_s1_q;
      buck_s1_q <= buck_mode_pin;
      buck_s2_q <= buck_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // charge progress
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    enter_topoff = 1'b0;
    unique case (state_q)
      ctc_pkg::ST_OFF: begin
        if (charge_enable) begin
          state_d = ctc_pkg::ST_FAST;
        end
      end
      ctc_pkg::ST_FAST: begin
        // current decay in cv; never with threshold off
        if (cv_s2_q && ith_code != ctc_pkg::ITH_DISABLE &&
            charge_current_ma <= 13'(ith_decode(ith_code))) begin
          state_d = ctc_pkg::ST_TOPOFF;
          enter_topoff = 1'b1;
        end
      end
      ctc_pkg::ST_TOPOFF: begin
        if (tif.expired) begin
          state_d = ctc_pkg::ST_DONE;
        end
      end
      ctc_pkg::ST_DONE: begin
        state_d = ctc_pkg::ST_DONE;
      end
    endcase
    // disabling the charger abandons any stage
    if (!charge_enable) begin
      state_d = ctc_pkg::ST_OFF;
      enter_topoff = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ctc_pkg::ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // timer starts on entry with the duration field; entry is gated
  assign tif.start = enter_topoff;
  assign tif.stop = (state_q == ctc_pkg::ST_TOPOFF) && !charge_enable;
  // duration code handed to the timer
  assign tif.duration = topoff_config_q[ctc_pkg::DUR_LSB +: ctc_pkg::DUR_W];

  ctc_topoff_timer #(
    .CYCLES_PER_SEC(CYCLES_PER_SEC)
  ) u_timer (
    .clk(clk),
    .resetn(resetn),
    .tif(tif)
  );

  // event pulse and state report on entry; done report
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      charger_event_irq <= 1'b0;
      charger_state_details <= ctc_pkg::DTLS_OFF;
    end else begin
      charger_event_irq <= enter_topoff;
      unique case (state_d)
        ctc_pkg::ST_OFF: charger_state_details <= ctc_pkg::DTLS_OFF;
        ctc_pkg::ST_FAST: charger_state_details <= ctc_pkg::DTLS_FAST;
        ctc_pkg::ST_TOPOFF: charger_state_details <= ctc_pkg::DTLS_TOPOFF;
        ctc_pkg::ST_DONE: charger_state_details <= ctc_pkg::DTLS_DONE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // decodes toward the analog loops
  // ----------------------------------------------------------------
  // termination per variant
  assign term_v = term_decode(sys_term_cfg_q[ctc_pkg::TERM_LSB +: ctc_pkg::TERM_W], VARIANT_B);

  always_comb begin
    unique case (sys_term_cfg_q[ctc_pkg::MIN_SYSTEM_VOLTAGE_LSB +: ctc_pkg::MIN_SYSTEM_VOLTAGE_W])
      2'h0: min_system_voltage_v = VARIANT_B ? ctc_pkg::MIN_SYSTEM_VOLTAGE_B0 : ctc_pkg::MIN_SYSTEM_VOLTAGE_A0;
      2'h1: min_system_voltage_v = VARIANT_B ? ctc_pkg::MIN_SYSTEM_VOLTAGE_B1 : ctc_pkg::MIN_SYSTEM_VOLTAGE_A1;
      2'h2: min_system_voltage_v = VARIANT_B ? ctc_pkg::MIN_SYSTEM_VOLTAGE_B2 : ctc_pkg::MIN_SYSTEM_VOLTAGE_A2;
      2'h3: min_system_voltage_v = VARIANT_B ? ctc_pkg::MIN_SYSTEM_VOLTAGE_B3 : ctc_pkg::MIN_SYSTEM_VOLTAGE_A3;
    endcase
  end

  // division by a constant; fine at this rate, the loop target moves slowly
  assign follow_v = 17'(battery_voltage) + 17'(battery_voltage) / ctc_pkg::FOLLOW_DIV;

  // system target, valid only in buck mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sys_regulation_target <= 17'h0_0000;
      sys_target_valid <= 1'b0;
    end else begin
      sys_target_valid <= buck_s2_q;
      if (sys_term_cfg_q[ctc_pkg::FOLLOW_DIS_BIT]) begin
        sys_regulation_target <= term_v;
      end else begin
        // larger of the two; independent of charge state
        sys_regulation_target <= (follow_v > min_system_voltage_v) ? follow_v : min_system_voltage_v;
      end
    end
  end

  // current limit and threshold outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      charge_current_limit_ma <= ctc_pkg::CC_FLOOR_MA;
      topoff_threshold_ma <= 10'h000;
      battery_term_voltage <= 17'h0_0000;
    end else begin
      if (fast_charge_current_code <= ctc_pkg::CC_FLOOR_CODE) begin
        charge_current_limit_ma <= ctc_pkg::CC_FLOOR_MA;
      end else if (fast_charge_current_code >= ctc_pkg::CC_MAX_CODE) begin
        charge_current_limit_ma <= 13'(32'(ctc_pkg::CC_MAX_CODE) * 32'(ctc_pkg::CC_STEP_MA));
      end else begin
        charge_current_limit_ma <=
          13'(32'(fast_charge_current_code) * 32'(ctc_pkg::CC_STEP_MA));
      end
      topoff_threshold_ma <= ith_decode(ith_code);
      battery_term_voltage <= term_v;
    end
  end
endmodule // ctc_top
`default_nettype wire

/* File: dv/ctc_top_props.sv */
`default_nettype none
// ------------------------------------------------
// checker on the top-level ports
// ------------------------------------------------
module ctc_top_props #(
  parameter bit VARIANT_B = 1'b0,
  parameter int unsigned CYCLES_PER_SEC = ctc_pkg::CLK_HZ
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [6:0] fast_charge_current_code,
  input wire logic [12:0] charge_current_limit_ma,
  input wire logic [9:0] topoff_threshold_ma,
  input wire logic [3:0] charger_state_details,
  input wire logic charger_event_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // wide count: the 70 minute run overflows 32 bits at full clock rate
  logic [39:0] cnt_q;
  localparam longint TMIN = 30 * longint'(CYCLES_PER_SEC) - 2;
  localparam longint TMAX = 4200 * longint'(CYCLES_PER_SEC) + 2;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // cycles spent reporting top-off
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) cnt_q <= '0;
    else if (charger_state_details == ctc_pkg::DTLS_TOPOFF) cnt_q <= cnt_q + 40'h1;
    else cnt_q <= '0;
  end
  AST_CC_STEP: assert property (
    fast_charge_current_code > 7'h02 && fast_charge_current_code < 7'h6e |=>
    charge_current_limit_ma == 13'($past(fast_charge_current_code)) * 13'h0032)
    else $error("current limit off the 50mA line");
  AST_CC_CLAMP: assert property (
    fast_charge_current_code >= 7'h6e |=> charge_current_limit_ma == 13'h157c)
    else $error("current limit not clamped");
  AST_ITH_SET: assert property (
    topoff_threshold_ma == 10'h0 || (topoff_threshold_ma >= 10'h0096 &&
    topoff_threshold_ma <= 10'h0352 && topoff_threshold_ma % 10'h0032 == 10'h0))
    else $error("threshold outside its set");
  AST_IRQ_ONE: assert property (charger_event_irq |=> !charger_event_irq)
    else $error("event longer than one cycle");
  AST_IRQ_ENTRY: assert property (
    $changed(charger_state_details) && charger_state_details == ctc_pkg::DTLS_TOPOFF
    |-> charger_event_irq) else $error("top-off entry without event");
  AST_FROM_FAST: assert property (
    charger_event_irq |-> $past(charger_state_details) == ctc_pkg::DTLS_FAST)
    else $error("top-off entered from a state other than fast charge");
  AST_NO_ITH: assert property (charger_event_irq |-> topoff_threshold_ma != 10'h0)
    else $error("top-off entered with threshold disabled");
  AST_DONE_AFTER: assert property (
    charger_state_details == ctc_pkg::DTLS_DONE && $past(charger_state_details) !=
    ctc_pkg::DTLS_DONE |-> $past(charger_state_details) == ctc_pkg::DTLS_TOPOFF)
    else $error("done reached without top-off");
  AST_SPAN: assert property (
    charger_state_details == ctc_pkg::DTLS_DONE && $past(charger_state_details) ==
    ctc_pkg::DTLS_TOPOFF |-> cnt_q >= TMIN && cnt_q <= TMAX)
    else $error("top-off span outside the duration range");
endmodule // ctc_top_props
bind ctc_top ctc_top_props #(.VARIANT_B(VARIANT_B), .CYCLES_PER_SEC(CYCLES_PER_SEC)) u_props (
  .clk(clk), .resetn(resetn), .fast_charge_current_code(fast_charge_current_code),
  .charge_current_limit_ma(charge_current_limit_ma), .topoff_threshold_ma(topoff_threshold_ma),
  .charger_state_details(charger_state_details), .charger_event_irq(charger_event_irq));
`default_nettype wire

/* File: dv/ctc_host_model.sv */
`default_nettype none
// ------------------------------------------------
// host side of the register port
// ------------------------------------------------
module ctc_host_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // one write; data turns over afterwards so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // one read; a spare cycle keeps reads apart
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
endmodule // ctc_host_model
`default_nettype wire

/* File: dv/tb_charge_topoff_term_config.sv */
`default_nettype none
module tb_charge_topoff_term_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, reg_wr, reg_rd, charge_enable, cv_mode_pin, buck_mode_pin, irq, p1, p2;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [12:0] charge_current_ma, lim;
  logic [15:0] battery_voltage;
  logic [6:0] fcc;
  logic [9:0] thr;
  logic [16:0] term, sys;
  logic valid;
  logic [3:0] dtls;
  logic [7:0] exp_q[$];
  logic [16:0] ms[4] = '{ctc_pkg::MIN_SYSTEM_VOLTAGE_A0, ctc_pkg::MIN_SYSTEM_VOLTAGE_A1, ctc_pkg::MIN_SYSTEM_VOLTAGE_A2,
    ctc_pkg::MIN_SYSTEM_VOLTAGE_A3};
  int err_total = 0, checks = 0, irq_cnt = 0, seed = 67917;
  ctc_host_model u_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata));
  ctc_top #(.VARIANT_B(1'b0), .CYCLES_PER_SEC(10)) u_dut (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .charge_enable(charge_enable), .cv_mode_pin(cv_mode_pin),
    .buck_mode_pin(buck_mode_pin), .charge_current_ma(charge_current_ma),
    .battery_voltage(battery_voltage), .fast_charge_current_code(fcc),
    .charge_current_limit_ma(lim), .topoff_threshold_ma(thr), .battery_term_voltage(term),
    .sys_regulation_target(sys), .sys_target_valid(valid), .charger_state_details(dtls),
    .charger_event_irq(irq));
  always #4 clk = ~clk;
  task automatic chk(input string n, input logic [16:0] e, input logic [16:0] s);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // note the expected read value, then let the host read
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.rd(a);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // read data is settled two edges after the read strobe
  always @(posedge clk) begin
    p1 <= reg_rd;
    p2 <= p1;
  end
  always @(negedge clk) begin
    if (irq === 1'b1) irq_cnt++;
    if (p2 === 1'b1) chk("reg_rdata", exp_q.pop_front(), 17'(reg_rdata));
  end
  // one charge cycle through top-off to done, duration code d
  task automatic run(input logic [2:0] d, input int secs);
    int n, k;
    u_host.wr(ctc_pkg::TOPOFF_CFG_OFS, {1'b0, d, 4'h2});
    charge_current_ma <= 13'h03e8;
    charge_enable <= 1'b1;
    cv_mode_pin <= 1'b1;
    repeat (6) @(posedge clk);
    chk("dtls", ctc_pkg::DTLS_FAST, dtls);
    k = irq_cnt;
    charge_current_ma <= 13'h0064 + 13'($random(seed) & 32'h3f);
    n = 0;
    while (irq_cnt == k && n < 20) begin @(posedge clk); n++; end
    chk("irq", 1, 17'(irq_cnt - k));
    chk("dtls", ctc_pkg::DTLS_TOPOFF, dtls);
    n = 0;
    while (dtls !== ctc_pkg::DTLS_DONE && n < 8000) begin @(posedge clk); n++; end
    chk("span", 1, 17'(n >= secs * 10 - 3 && n <= secs * 10 + 3));
    repeat (3) @(posedge clk);
    chk("sys", 17'h0_a280, sys);
    charge_enable <= 1'b0;
    repeat (3) @(posedge clk);
    chk("dtls", ctc_pkg::DTLS_OFF, dtls);
    $display("test run %0d done", d);
  endtask
  initial begin
    int i;
    logic [6:0] v;
    clk = 0; resetn = 0; charge_enable = 0; cv_mode_pin = 0; buck_mode_pin = 1;
    charge_current_ma = 13'h03e8; battery_voltage = 16'h7530; fcc = 7'h00;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    rdx(ctc_pkg::TOPOFF_CFG_OFS, 8'h32);
    rdx(ctc_pkg::SYS_TERM_CFG_OFS, 8'h24);
    u_host.wr(8'h20, 8'h5a);
    rdx(8'h20, 8'h00);
    u_host.wr(ctc_pkg::TOPOFF_CFG_OFS, 8'hb5);
    rdx(ctc_pkg::TOPOFF_CFG_OFS, 8'hb5);
    $display("test registers done");
    for (i = 0; i < 16; i++) begin
      u_host.wr(ctc_pkg::TOPOFF_CFG_OFS, 8'(i));
      repeat (2) @(posedge clk);
      chk("thr", (i == 0) ? 17'h0 : 17'(100 + 50 * i), 17'(thr));
    end
    for (i = 0; i < 48; i++) begin
      v = (i < 3) ? 7'(8'h6d + i) : 7'($random(seed));
      fcc <= v;
      repeat (2) @(posedge clk);
      chk("lim", v < 3 ? 17'h64 : v >= 7'h6e ? 17'h157c : 17'(v * 50), 17'(lim));
    end
    $display("test decode done");
    for (i = 0; i < 32; i++) begin
      u_host.wr(ctc_pkg::SYS_TERM_CFG_OFS, 8'(8'h80 | i));
      repeat (3) @(posedge clk);
      chk("term", ctc_pkg::TERM_BASE_A + 17'(125 * i), term);
      chk("sys", ctc_pkg::TERM_BASE_A + 17'(125 * i), sys);
    end
    chk("valid", 1, 17'(valid));
    buck_mode_pin <= 1'b0;
    repeat (4) @(posedge clk);
    chk("valid", 0, 17'(valid));
    buck_mode_pin <= 1'b1;
    repeat (4) @(posedge clk);
    for (i = 0; i < 4; i++) begin
      u_host.wr(ctc_pkg::SYS_TERM_CFG_OFS, 8'((i << 5) | 4));
      repeat (3) @(posedge clk);
      chk("sys", ms[i], sys);
    end
    battery_voltage <= 16'h9c40;
    repeat (3) @(posedge clk);
    chk("sys", 17'h0_a280, sys);
    $display("test voltages done");
    run(3'h0, 30);
    run(3'h1, 600);
    u_host.wr(ctc_pkg::TOPOFF_CFG_OFS, 8'h30);
    i = irq_cnt;
    charge_current_ma <= 13'h0000;
    charge_enable <= 1'b1;
    repeat (400) @(posedge clk);
    chk("dtls", ctc_pkg::DTLS_FAST, dtls);
    chk("irq", 0, 17'(irq_cnt - i));
    cv_mode_pin <= 1'b0;
    u_host.wr(ctc_pkg::TOPOFF_CFG_OFS, 8'h32);
    repeat (20) @(posedge clk);
    chk("dtls", ctc_pkg::DTLS_FAST, dtls);
    cv_mode_pin <= 1'b1;
    repeat (4) @(posedge clk);
    chk("dtls", ctc_pkg::DTLS_TOPOFF, dtls);
    chk("irq", 1, 17'(irq_cnt - i));
    charge_enable <= 1'b0;
    repeat (3) @(posedge clk);
    chk("dtls", ctc_pkg::DTLS_OFF, dtls);
    $display("test disabled threshold done");
    tally_and_finish();
  end
  initial begin
    #(8 * 30000);
    err_total++;
    tally_and_finish();
  end
endmodule // tb_charge_topoff_term_config
`default_nettype wire
